// *** rtl/lmh_consts.vh ***
`ifndef LMH_CONSTS_VH
`define LMH_CONSTS_VH
// ****************
// register offsets
// ****************
`define LMH_OFF_CTRL 12'h000
`define LMH_OFF_STAT 12'h004
`define LMH_OFF_IRQ 12'h008
`define LMH_OFF_MASK 12'h00c
`define LMH_OFF_SPEED 12'h010
`define LMH_OFF_ITHR 12'h014
`define LMH_OFF_HOME 12'h018
`define LMH_OFF_CHECK 12'h01c
`define LMH_OFF_INIT 12'h020
`define LMH_OFF_POS 12'h024
// ****************
// fields
// ****************
`define LMH_MODE_ACT 3'h0
`define LMH_MODE_STOP_OUT 3'h1
`define LMH_MODE_STOP_IN 3'h2
`define LMH_MODE_TRIG_OUT 3'h3
`define LMH_MODE_TRIG_IN 3'h4
`define LMH_CTRL_REQ 3
`define LMH_CTRL_ONCE 4
`define LMH_IRQ_DONE 0
`define LMH_IRQ_ERR 1
`define LMH_PCT_FULL 8'h64
`define LMH_ZERO32 32'h00000000
`endif

// *** rtl/lmh_homing.v ***
// The register addresses and register access over APB are this design's own decisions.
`include "lmh_consts.vh"
module lmh_homing #(
	parameter PW = 32,
	parameter CW = 16,
	parameter MOVE_TIMEOUT = 32'd100000000
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [PW-1:0] meas_pos,
	input wire [CW-1:0] motor_current,
	input wire [CW-1:0] max_current,
	input wire trigger_in,
	input wire at_target,
	output reg [PW-1:0] target_pos,
	output reg [15:0] move_speed,
	output reg move_en,
	output reg move_dir_out,
	output reg target_mode,
	output reg pos_load,
	output reg [PW-1:0] pos_load_value,
	output reg homed,
	output reg home_error,
	output reg irq
);
	// ****************
	// states
	// ****************
	localparam ST_IDLE = 9'h001;
	localparam ST_PREP = 9'h002;
	localparam ST_SEEK = 9'h004;
	localparam ST_LOAD = 9'h008;
	localparam ST_CHECK = 9'h010;
	localparam ST_BACK = 9'h020;
	localparam ST_INIT = 9'h040;
	localparam ST_DONE = 9'h080;
	localparam ST_ERR = 9'h100;

	reg [8:0] state_reg;
	reg [2:0] mode_reg;
	reg once_reg;
	reg req_reg;
	reg done_once_reg;
	reg [15:0] speed_reg;
	reg [7:0] ithr_reg;
	reg [PW-1:0] home_reg;
	reg [PW-1:0] check_reg;
	reg [PW-1:0] init_reg;
	reg [1:0] irq_stat_reg;
	reg [1:0] irq_mask_reg;
	reg trig_d_reg;
	reg [31:0] tmo_reg;
	reg [31:0] rdata_next;
	reg [1:0] ev_done;
	wire wr_acc;
	wire rd_acc;
	wire trig_rise;
	wire stop_hit;
	wire [CW+7:0] cur_scaled;
	wire [CW+7:0] max_scaled;
	wire stop_mode;
	wire mode_out;

	// ****************
	// helpers
	// ****************
	function addr_hit;
		input [11:0] a;
		input [11:0] off;
		begin
			addr_hit = (a == off);
		end
	endfunction

	assign wr_acc = psel & penable & pwrite & pready;
	assign rd_acc = psel & penable & ~pwrite & ~pready;
	assign trig_rise = trigger_in & ~trig_d_reg;
	// current reaches threshold percent of maximum
	assign cur_scaled = motor_current * `LMH_PCT_FULL;
	assign max_scaled = max_current * ithr_reg;
	assign stop_hit = (cur_scaled >= max_scaled);
	assign stop_mode = (mode_reg == `LMH_MODE_STOP_OUT) | (mode_reg == `LMH_MODE_STOP_IN);
	assign mode_out = (mode_reg == `LMH_MODE_STOP_OUT) | (mode_reg == `LMH_MODE_TRIG_OUT);

	always @* begin
		rdata_next = `LMH_ZERO32;
		case (1'b1)
			addr_hit(paddr, `LMH_OFF_CTRL): rdata_next = {27'h0, once_reg, req_reg, mode_reg};
			addr_hit(paddr, `LMH_OFF_STAT): rdata_next = {22'h0, state_reg[7:0], home_error, homed};
			addr_hit(paddr, `LMH_OFF_IRQ): rdata_next = {30'h0, irq_stat_reg};
			addr_hit(paddr, `LMH_OFF_MASK): rdata_next = {30'h0, irq_mask_reg};
			addr_hit(paddr, `LMH_OFF_SPEED): rdata_next = {16'h0, speed_reg};
			addr_hit(paddr, `LMH_OFF_ITHR): rdata_next = {24'h0, ithr_reg};
			addr_hit(paddr, `LMH_OFF_HOME): rdata_next = home_reg;
			addr_hit(paddr, `LMH_OFF_CHECK): rdata_next = check_reg;
			addr_hit(paddr, `LMH_OFF_INIT): rdata_next = init_reg;
			addr_hit(paddr, `LMH_OFF_POS): rdata_next = meas_pos;
			default: rdata_next = `LMH_ZERO32;
		endcase
	end

	// ****************
	// apb slave
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `LMH_ZERO32;
			mode_reg <= `LMH_MODE_ACT;
			once_reg <= 1'b1;
			speed_reg <= 16'h0000;
			ithr_reg <= 8'h00;
			home_reg <= `LMH_ZERO32;
			check_reg <= `LMH_ZERO32;
			init_reg <= `LMH_ZERO32;
			irq_mask_reg <= 2'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			if (rd_acc)
				prdata <= rdata_next;
			if (wr_acc) begin
				if (addr_hit(paddr, `LMH_OFF_CTRL)) begin
					mode_reg <= pwdata[2:0];
					once_reg <= pwdata[`LMH_CTRL_ONCE];
				end
				if (addr_hit(paddr, `LMH_OFF_MASK))
					irq_mask_reg <= pwdata[1:0];
				if (addr_hit(paddr, `LMH_OFF_SPEED))
					speed_reg <= pwdata[15:0];
				if (addr_hit(paddr, `LMH_OFF_ITHR))
					ithr_reg <= pwdata[7:0];
				if (addr_hit(paddr, `LMH_OFF_HOME))
					home_reg <= pwdata[PW-1:0];
				if (addr_hit(paddr, `LMH_OFF_CHECK))
					check_reg <= pwdata[PW-1:0];
				if (addr_hit(paddr, `LMH_OFF_INIT))
					init_reg <= pwdata[PW-1:0];
			end
		end
	end

	// ****************
	// sequencer
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			req_reg <= 1'b1;
			done_once_reg <= 1'b0;
			trig_d_reg <= 1'b0;
			tmo_reg <= `LMH_ZERO32;
			target_pos <= `LMH_ZERO32;
			move_speed <= 16'h0000;
			move_en <= 1'b0;
			move_dir_out <= 1'b0;
			target_mode <= 1'b0;
			pos_load <= 1'b0;
			pos_load_value <= `LMH_ZERO32;
			homed <= 1'b0;
			home_error <= 1'b0;
			ev_done <= 2'h0;
		end else begin
			trig_d_reg <= trigger_in;
			pos_load <= 1'b0;
			ev_done <= 2'h0;
			move_speed <= speed_reg;
			if (wr_acc && addr_hit(paddr, `LMH_OFF_CTRL) && pwdata[`LMH_CTRL_REQ])
				req_reg <= 1'b1;
			case (state_reg)
				ST_IDLE: begin
					move_en <= 1'b0;
					// start only on request; single-shot skips those after a completed homing
					if (req_reg) begin
						req_reg <= 1'b0;
						if (!(once_reg && done_once_reg)) begin
							homed <= 1'b0;
							home_error <= 1'b0;
							state_reg <= ST_PREP;
						end
					end
				end
				ST_PREP: begin
					target_mode <= 1'b0;
					if (mode_reg == `LMH_MODE_ACT) begin
						state_reg <= ST_LOAD;
					end else if (!stop_mode && trigger_in) begin
						move_en <= 1'b1;
						move_dir_out <= ~mode_out;
					end else begin
						move_en <= 1'b1;
						move_dir_out <= mode_out;
						state_reg <= ST_SEEK;
					end
				end
				ST_SEEK: begin
					if ((stop_mode && stop_hit) || (!stop_mode && trig_rise)) begin
						move_en <= 1'b0;
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					pos_load <= 1'b1;
					pos_load_value <= home_reg;
					move_en <= 1'b0;
					target_mode <= 1'b1;
					target_pos <= check_reg;
					tmo_reg <= `LMH_ZERO32;
					state_reg <= ST_CHECK;
				end
				ST_CHECK, ST_BACK, ST_INIT: begin
					move_en <= 1'b1;
					tmo_reg <= tmo_reg + 32'h00000001;
					if (tmo_reg >= MOVE_TIMEOUT) begin
						move_en <= 1'b0;
						home_error <= 1'b1;
						state_reg <= ST_ERR;
					end else if (at_target && tmo_reg != `LMH_ZERO32) begin
						tmo_reg <= `LMH_ZERO32;
						if (state_reg == ST_CHECK) begin
							target_pos <= home_reg;
							state_reg <= ST_BACK;
						end else if (state_reg == ST_BACK) begin
							target_pos <= init_reg;
							state_reg <= ST_INIT;
						end else begin
							state_reg <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					move_en <= 1'b0;
					homed <= 1'b1;
					done_once_reg <= 1'b1;
					ev_done <= 2'h1;
					state_reg <= ST_IDLE;
				end
				ST_ERR: begin
					move_en <= 1'b0;
					ev_done <= 2'h2;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ****************
	// interrupts
	// ****************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 2'h0;
			irq <= 1'b0;
		end else begin
			// clear only the bits handed out; a new event still sets
			if (psel && penable && !pwrite && pready && addr_hit(paddr, `LMH_OFF_IRQ))
				irq_stat_reg <= (irq_stat_reg & ~prdata[1:0]) | ev_done;
			else
				irq_stat_reg <= irq_stat_reg | ev_done;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end
endmodule

// *** verification/lmh_homing_assertions.sv ***
// ****
// checks
// ****
module lmh_homing_checker(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pos_load,
	input wire logic move_en,
	input wire logic target_mode,
	input wire logic at_target,
	input wire logic homed,
	input wire logic home_error
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence leg_s;
		##[1:3] target_mode;
	endsequence
	apb_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("late ready");
	rdy_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	load_pulse_a: assert property (pos_load |=> !pos_load) else $error("load held");
	check_leg_a: assert property (pos_load |-> leg_s) else $error("no target move");
	load_unhomed_a: assert property (pos_load |-> !homed) else $error("homed early");
	err_unhomed_a: assert property (home_error |-> !homed) else $error("homed on error");
	err_halt_a: assert property ($rose(home_error) |-> ##[0:1] !move_en) else $error("moving on error");
	homed_arrive_a: assert property ($rose(homed) |-> at_target || $past(at_target)) else $error("off target");
endmodule

// *** verification/lmh_slider_model.sv ***
// ****
// slider
// ****
module lmh_slider_model(
	input wire logic pclk,
	input wire logic [31:0] target_pos,
	input wire logic move_en,
	input wire logic move_dir_out,
	input wire logic target_mode,
	input wire logic pos_load,
	input wire logic [31:0] pos_load_value,
	input wire logic blocked,
	output logic [31:0] meas_pos,
	output logic [15:0] motor_current,
	output logic [15:0] max_current,
	output logic trigger_in,
	output logic at_target
);
	timeunit 1ns;
	timeprecision 1ps;
	int phys = 10;
	int off = 0;
	int cnt = 0;
	int nx;
	assign meas_pos = phys + off;
	assign max_current = 16'h0100;
	assign trigger_in = phys >= 30 && phys <= 34;
	assign at_target = meas_pos == target_pos;
	assign motor_current = move_en && !target_mode && phys == (move_dir_out ? 60 : 0) ? 16'h0100 : 16'h0000;
	always @(posedge pclk) begin
		cnt <= cnt + 1;
		nx = !target_mode ? (move_dir_out ? phys + 1 : phys - 1) : target_pos > meas_pos ? phys + 1 : target_pos < meas_pos ? phys - 1 : phys;
		if (pos_load) off <= pos_load_value - phys;
		if (move_en && cnt % 8 == 0 && !(target_mode && blocked) && nx >= 0 && nx <= 60) phys <= nx;
	end
endmodule

// *** verification/tb_linear_motor_homing_sequencer.sv ***
// ****
// bench
// ****
module tb_linear_motor_homing_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blocked = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, meas_pos, target_pos, pos_load_value, rd;
	logic [15:0] motor_current, max_current, move_speed, rnd = 16'h002a;
	logic pready, pslverr, trigger_in, at_target, move_en, move_dir_out, target_mode, pos_load, homed, home_error, irq;
	int err_total = 0;
	int total_checks = 0;
	always #5 pclk = ~pclk;
	lmh_homing #(.MOVE_TIMEOUT(32'd1000)) uut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .meas_pos, .motor_current, .max_current, .trigger_in, .at_target, .target_pos, .move_speed,
		.move_en, .move_dir_out, .target_mode, .pos_load, .pos_load_value, .homed, .home_error, .irq);
	lmh_slider_model sl(.pclk, .target_pos, .move_en, .move_dir_out, .target_mode, .pos_load, .pos_load_value,
		.blocked, .meas_pos, .motor_current, .max_current, .trigger_in, .at_target);
	task chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task run(input logic [2:0] m, input logic [31:0] c, input int ep, input logic b);
		int lp;
		logic seen;
		lp = -1;
		seen = 0;
		blocked <= b;
		apb(1, 12'h01c, c);
		apb(1, 12'h000, {27'h0000000, 2'b01, m});
		repeat (3000) begin
			@(posedge pclk);
			if (pos_load === 1'b1) lp = sl.phys;
			if (pos_load === 1'b1) chk(pos_load_value, 32'h64);
			if (move_en === 1'b1) chk(move_speed, rnd);
			if (meas_pos === c) seen = 1;
			if ((lp >= 0 && homed === 1'b1) || (b && home_error === 1'b1)) break;
		end
		repeat (3) @(posedge pclk);
		if (b) begin
			chk(home_error, 1);
			chk(move_en, 0);
			chk(homed, 0);
		end else begin
			chk(lp, ep);
			chk(seen, 1);
			chk(meas_pos, 32'h64);
			chk(homed, 1);
		end
		chk(irq, 1);
		apb(0, 12'h008, 0);
		chk(rd, b ? 2 : 1);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		$display("test %0d done", m);
	endtask
	initial begin
		#500000;
		err_total++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3000 && homed !== 1'b1; i++) @(posedge pclk);
		chk(homed, 1);
		chk(sl.phys, 10);
		chk(meas_pos, 0);
		rnd = nxt(rnd);
		apb(1, 12'h010, {16'h0000, rnd});
		apb(1, 12'h014, 32'(nxt(rnd) % 100) + 1);
		apb(1, 12'h018, 32'h64);
		apb(1, 12'h020, 32'h64);
		apb(1, 12'h00c, 32'h3);
		apb(0, 12'h008, 0);
		chk(rd, 1);
		apb(0, 12'h0fc, 0);
		chk(rd, 0);
		run(1, 32'h5a, 0, 1);
		run(1, 32'h5a, 60, 0);
		run(4, 32'h5a, 34, 0);
		run(3, 32'h5a, 30, 0);
		run(4, 32'h5a, 34, 0);
		run(2, 32'h6e, 0, 0);
		apb(1, 12'h000, 32'h18);
		repeat (200) @(posedge pclk);
		chk(homed, 1);
		chk(sl.phys, 0);
		apb(0, 12'h024, 0);
		chk(rd, 32'h64);
		finish_test;
	end
endmodule
bind lmh_homing lmh_homing_checker chk_i(.pclk, .presetn, .psel, .penable, .pready, .pos_load, .move_en,
	.target_mode, .at_target, .homed, .home_error);
